// >>> image_accel_ctrl_regs.sv
// Purpose : register bank and main control of the image accelerator
// Assumes : 125 MHz clk; events arrive from datapath logic on clk
// Notes   : one-cycle registered answer to every register access
//
// Overview of operation
// - error flag bit 21 reads pending; write 0 clears, 1 keeps
// - line-end flag bit 20 reads pending; write 0 clears, 1 keeps
// - line-end event is raised once per finished source line
// - line-end marks internal processing done, not buffer drain
// - bit 17 enables the error interrupt when 1; resets to 0
// - bit 16 enables the line-end interrupt when 1; resets to 0
// - bit 15 adds dummy points after the last Y line
// - bit 14 turns on automatic hot point calculation
// - bit 11 adds dummy points before the first Y line
// - bit 9 adds dummy columns at left and right X edges
// - bits 7..0 give source 1 address bits 31..24; reset 0
// - unused control bits read undefined; software writes zero
// - all registers are 32-bit words at offsets from the base
// - dma mode bit: 0 single, 1 burst transfers
// - dma allow bit enables dma; drops at end of one image
`timescale 1ns/1ps
`default_nettype none

`include "image_accel_map.svh"

module image_accel_ctrl_regs (
   // clock, reset, enable
   input  wire logic                     clk,
   input  wire logic                     resetn,
   input  wire logic                     ce,
   // register access
   input  wire image_accel_pkg::bus_req_t bus_req,
   output var  image_accel_pkg::bus_rsp_t bus_rsp,
   // datapath events
   input  wire logic                     err_event,
   input  wire logic                     line_done_event,
   input  wire logic                     image_done,
   // datapath controls
   output var  image_accel_pkg::ctrl_t    ctrl,
   output var  logic [13:0][31:0]        cfg_words,
   // interrupt
   output var  logic                     irq
);
   import image_accel_pkg::*;

   // ==========================================================
   // reset release
   logic rst_meta_q;
   logic rst_n;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rst_meta_q <= 1'b0;
         rst_n      <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_n      <= rst_meta_q;
      end
   end

   // ==========================================================
   // decode
   regs_state_t s_q;
   regs_state_t s_d;
   logic        acc;
   logic        mapped;
   logic        wr_main;
   logic [3:0]  idx;
   logic [3:0]  widx;
   logic [31:0] main_rd;
   logic [1:0]  flag_set;
   logic [1:0]  flag_clr;
   logic [1:0]  flag_q;

   assign acc  = ce && bus_req.valid;
   assign idx  = bus_req.addr[5:2];
   assign widx = idx - 4'h1;

   // only aligned words from the base up to the last register are mapped; others answer with err
   assign mapped = (bus_req.addr[7:6] == 2'b00)
                && (bus_req.addr[1:0] == 2'b00)
                && (idx <= `IA_LAST_INDEX);

   assign wr_main = acc && bus_req.write && mapped
                 && (bus_req.addr == `IA_OFF_MAIN_CONTROL);

   // ==========================================================
   // pending flags: index 1 error, index 0 line end
   // line end comes from the scaler core once per source line,
   // so software sees it before the write buffer has drained
   assign flag_set = {err_event, line_done_event};
   assign flag_clr = {
      wr_main && !bus_req.wdata[`IA_B_PROC_ERROR_FLAG],
      wr_main && !bus_req.wdata[`IA_B_LINE_DONE_FLAG]
   };

   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_flag
         flag_cell u_flag (
            .clk     (clk),
            .rst_n   (rst_n),
            .ce      (ce),
            .set_evt (flag_set[g]),
            .clr     (flag_clr[g]),
            .flag_q  (flag_q[g])
         );
      end
   endgenerate

   // ==========================================================
   // main control read image
   // unused positions read as zero, a legal undefined value
   always_comb begin
      main_rd = 32'h0000_0000;
      main_rd[`IA_B_PROC_ERROR_FLAG]   = flag_q[1];
      main_rd[`IA_B_LINE_DONE_FLAG]    = flag_q[0];
      main_rd[`IA_B_PROC_ERROR_IRQ_EN] = s_q.proc_error_irq_enable;
      main_rd[`IA_B_LINE_DONE_IRQ_EN]  = s_q.line_done_irq_enable;
      main_rd[`IA_B_BOTTOM_DUMMY_LINE] = s_q.ctrl.bottom_dummy_line_add;
      main_rd[`IA_B_AUTO_HOT_POINT]    = s_q.ctrl.auto_hot_point;
      main_rd[`IA_B_DMA_BURST_SELECT]  = s_q.ctrl.dma_burst_select;
      main_rd[`IA_B_DMA_ALLOW]         = s_q.ctrl.dma_allow;
      main_rd[`IA_B_TOP_DUMMY_LINE]    = s_q.ctrl.top_dummy_line_add;
      main_rd[`IA_B_PIXEL_FORMAT]      = s_q.ctrl.pixel_format_select;
      main_rd[`IA_B_EDGE_DUMMY_COLUMN] = s_q.ctrl.edge_dummy_column_add;
      main_rd[`IA_B_PERIOD_CORRECTION] = s_q.ctrl.period_correction;
      main_rd[`IA_B_SRC1_HIGH_MSB:`IA_B_SRC1_HIGH_LSB] =
         s_q.ctrl.src_one_addr_high;
   end

   // ==========================================================
   // next state
   always_comb begin
      s_d = s_q;
      s_d.rsp.ack = 1'b0;
      s_d.rsp.err = 1'b0;
      if (acc) begin
         s_d.rsp.ack   = 1'b1;
         s_d.rsp.rdata = 32'h0000_0000;
         if (!mapped) begin
            // writes are dropped, reads return zero
            s_d.rsp.err = 1'b1;
         end else if (bus_req.write) begin
            if (idx == 4'h0) begin
               s_d.proc_error_irq_enable =
                  bus_req.wdata[`IA_B_PROC_ERROR_IRQ_EN];
               s_d.line_done_irq_enable =
                  bus_req.wdata[`IA_B_LINE_DONE_IRQ_EN];
               s_d.ctrl.bottom_dummy_line_add =
                  bus_req.wdata[`IA_B_BOTTOM_DUMMY_LINE];
               s_d.ctrl.auto_hot_point =
                  bus_req.wdata[`IA_B_AUTO_HOT_POINT];
               s_d.ctrl.dma_burst_select =
                  bus_req.wdata[`IA_B_DMA_BURST_SELECT];
               s_d.ctrl.dma_allow =
                  bus_req.wdata[`IA_B_DMA_ALLOW];
               s_d.ctrl.top_dummy_line_add =
                  bus_req.wdata[`IA_B_TOP_DUMMY_LINE];
               // stored as written; 0 is reserved and left to software
               s_d.ctrl.pixel_format_select =
                  bus_req.wdata[`IA_B_PIXEL_FORMAT];
               s_d.ctrl.edge_dummy_column_add =
                  bus_req.wdata[`IA_B_EDGE_DUMMY_COLUMN];
               s_d.ctrl.period_correction =
                  bus_req.wdata[`IA_B_PERIOD_CORRECTION];
               s_d.ctrl.src_one_addr_high =
                  bus_req.wdata[`IA_B_SRC1_HIGH_MSB:`IA_B_SRC1_HIGH_LSB];
            end else begin
               s_d.words[widx] = bus_req.wdata;
            end
         end else begin
            if (idx == 4'h0) begin
               s_d.rsp.rdata = main_rd;
            end else begin
               s_d.rsp.rdata = s_q.words[widx];
            end
         end
      end
      // end of one image withdraws dma permission; beats a same-cycle set
      if (image_done) begin
         s_d.ctrl.dma_allow = 1'b0;
      end
      // one cycle behind the flags, so the pin is glitch free
      s_d.irq = (flag_q[1] && s_q.proc_error_irq_enable)
             || (flag_q[0] && s_q.line_done_irq_enable);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '0;
         s_q.ctrl.period_correction <= `IA_RST_PERIOD_CORRECTION;
         s_q.ctrl.src_one_addr_high <= `IA_RST_SRC1_HIGH;
      end else if (ce) begin
         s_q <= s_d;
      end
   end

   // ==========================================================
   // outputs
   assign bus_rsp   = s_q.rsp;
   assign ctrl      = s_q.ctrl;
   assign cfg_words = s_q.words;
   assign irq       = s_q.irq;

   // ==========================================================
   // checks
   sequence s_wr_main;
      ce && bus_req.valid && bus_req.write
         && bus_req.addr == `IA_OFF_MAIN_CONTROL;
   endsequence

   sequence s_rd_main;
      ce && bus_req.valid && !bus_req.write
         && bus_req.addr == `IA_OFF_MAIN_CONTROL;
   endsequence

   property p_err_clear;
      @(posedge clk) disable iff (!rst_n)
      s_wr_main ##0 (!bus_req.wdata[21] && !err_event) |=> !flag_q[1];
   endproperty
   a_err_clear: assert property (p_err_clear)
      else $error("error flag not cleared by write of 0");

   property p_err_keep;
      @(posedge clk) disable iff (!rst_n)
      s_wr_main ##0 (bus_req.wdata[21] && flag_q[1]) |=> flag_q[1];
   endproperty
   a_err_keep: assert property (p_err_keep)
      else $error("error flag lost on write of 1");

   property p_line_clear;
      @(posedge clk) disable iff (!rst_n)
      s_wr_main ##0 (!bus_req.wdata[20] && !line_done_event)
         |=> !flag_q[0];
   endproperty
   a_line_clear: assert property (p_line_clear)
      else $error("line flag not cleared by write of 0");

   property p_line_set;
      @(posedge clk) disable iff (!rst_n)
      (ce && line_done_event) |=> flag_q[0];
   endproperty
   a_line_set: assert property (p_line_set)
      else $error("line end event did not set its flag");

   property p_read_main;
      @(posedge clk) disable iff (!rst_n)
      s_rd_main |=> bus_rsp.ack
         && bus_rsp.rdata[21] == $past(flag_q[1])
         && bus_rsp.rdata[20] == $past(flag_q[0])
         && bus_rsp.rdata[17] == $past(s_q.proc_error_irq_enable)
         && bus_rsp.rdata[31:22] == 10'h000;
   endproperty
   a_read_main: assert property (p_read_main)
      else $error("main control read image wrong");

   property p_irq_on;
      @(posedge clk) disable iff (!rst_n)
      (ce && flag_q[1] && s_q.proc_error_irq_enable) |=> irq;
   endproperty
   a_irq_on: assert property (p_irq_on)
      else $error("enabled pending error did not raise irq");

   property p_irq_masked;
      @(posedge clk) disable iff (!rst_n)
      (ce && !(flag_q[1] && s_q.proc_error_irq_enable)
          && !(flag_q[0] && s_q.line_done_irq_enable)) |=> !irq;
   endproperty
   a_irq_masked: assert property (p_irq_masked)
      else $error("irq high with no enabled pending flag");

   property p_fields;
      @(posedge clk) disable iff (!rst_n)
      s_wr_main ##0 !image_done |=>
         ctrl.src_one_addr_high == $past(bus_req.wdata[7:0])
         && ctrl.top_dummy_line_add == $past(bus_req.wdata[11])
         && ctrl.bottom_dummy_line_add == $past(bus_req.wdata[15])
         && ctrl.edge_dummy_column_add == $past(bus_req.wdata[9])
         && ctrl.auto_hot_point == $past(bus_req.wdata[14])
         && ctrl.dma_burst_select == $past(bus_req.wdata[13])
         && ctrl.dma_allow == $past(bus_req.wdata[12]);
   endproperty
   a_fields: assert property (p_fields)
      else $error("control field not taken from write");

   property p_dma_done;
      @(posedge clk) disable iff (!rst_n)
      (ce && image_done) |=> !ctrl.dma_allow;
   endproperty
   a_dma_done: assert property (p_dma_done)
      else $error("dma allow survived end of image");

   property p_unmapped;
      @(posedge clk) disable iff (!rst_n)
      (acc && !mapped) |=> bus_rsp.ack && bus_rsp.err
         && bus_rsp.rdata == 32'h0000_0000;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped access not refused");

   property p_word_rw;
      @(posedge clk) disable iff (!rst_n)
      (acc && mapped && bus_req.write && idx != 4'h0)
         |=> cfg_words[$past(widx)] == $past(bus_req.wdata);
   endproperty
   a_word_rw: assert property (p_word_rw)
      else $error("register word not written");

   property p_err_set;
      @(posedge clk) disable iff (!rst_n)
      (ce && err_event) |=> flag_q[1];
   endproperty
   a_err_set: assert property (p_err_set)
      else $error("error event did not set its flag");

   property p_line_keep;
      @(posedge clk) disable iff (!rst_n)
      s_wr_main ##0 (bus_req.wdata[20] && flag_q[0]) |=> flag_q[0];
   endproperty
   a_line_keep: assert property (p_line_keep)
      else $error("line flag lost on write of 1");

   property p_line_irq;
      @(posedge clk) disable iff (!rst_n)
      (ce && flag_q[0] && s_q.line_done_irq_enable) |=> irq;
   endproperty
   a_line_irq: assert property (p_line_irq)
      else $error("enabled pending line end did not raise irq");

   property p_enables;
      @(posedge clk) disable iff (!rst_n)
      s_wr_main |=>
         s_q.proc_error_irq_enable == $past(bus_req.wdata[17])
         && s_q.line_done_irq_enable == $past(bus_req.wdata[16]);
   endproperty
   a_enables: assert property (p_enables)
      else $error("interrupt enable not taken from write");

   property p_format_kept;
      @(posedge clk) disable iff (!rst_n)
      s_wr_main |=>
         ctrl.pixel_format_select == $past(bus_req.wdata[10])
         && ctrl.period_correction == $past(bus_req.wdata[8]);
   endproperty
   a_format_kept: assert property (p_format_kept)
      else $error("format or period field not taken from write");

   property p_idle_quiet;
      @(posedge clk) disable iff (!rst_n)
      (ce && !bus_req.valid) |=> !bus_rsp.ack && !bus_rsp.err;
   endproperty
   a_idle_quiet: assert property (p_idle_quiet)
      else $error("answer without a request");

endmodule // image_accel_ctrl_regs

`default_nettype wire

// >>> image_accel_map.svh
// Purpose : offsets, field positions, reset values of the image
//           accelerator register bank
// Assumes : byte addresses, one aligned 32-bit word per register
// Notes   : definitions only
`ifndef IMAGE_ACCEL_MAP_SVH
`define IMAGE_ACCEL_MAP_SVH

// ==========================================================
// register byte offsets from the block base
`define IA_OFF_MAIN_CONTROL       8'h00
`define IA_OFF_SOURCE1_GRAY_RATIO 8'h04
`define IA_OFF_SOURCE0_GRAY_RATIO 8'h08
`define IA_OFF_GLYPH_AREA_COLOR   8'h0c
`define IA_OFF_NON_GLYPH_COLOR    8'h10
`define IA_OFF_SOURCE1_READ_STEP  8'h14
`define IA_OFF_CONTROL_TWO        8'h18
`define IA_OFF_DEST_X_WRITE_STEP  8'h1c
`define IA_OFF_DEST_Y_WRITE_STEP  8'h20
`define IA_OFF_SOURCE_IMAGE_SIZE  8'h24
`define IA_OFF_DEST_IMAGE_SIZE    8'h28
`define IA_OFF_SOURCE0_START_ADDR 8'h2c
`define IA_OFF_DEST_START_ADDR    8'h30
`define IA_OFF_CONTROL_ONE        8'h34
`define IA_OFF_SOURCE0_READ_STEP  8'h38

// word index of the last mapped register
`define IA_LAST_INDEX             4'he

// ==========================================================
// main_control field positions
`define IA_B_PROC_ERROR_FLAG      21
`define IA_B_LINE_DONE_FLAG       20
`define IA_B_PROC_ERROR_IRQ_EN    17
`define IA_B_LINE_DONE_IRQ_EN     16
`define IA_B_BOTTOM_DUMMY_LINE    15
`define IA_B_AUTO_HOT_POINT       14
`define IA_B_DMA_BURST_SELECT     13
`define IA_B_DMA_ALLOW            12
`define IA_B_TOP_DUMMY_LINE       11
`define IA_B_PIXEL_FORMAT         10
`define IA_B_EDGE_DUMMY_COLUMN    9
`define IA_B_PERIOD_CORRECTION    8
`define IA_B_SRC1_HIGH_MSB        7
`define IA_B_SRC1_HIGH_LSB        0

// ==========================================================
// reset values
`define IA_RST_PERIOD_CORRECTION  1'b1
`define IA_RST_SRC1_HIGH          8'h00
`define IA_RST_WORD               32'h0000_0000

`endif

// >>> image_accel_pkg.sv
// Purpose : types shared by the image accelerator register bank
// Assumes : image_accel_map.svh holds the numbers
// Notes   : all carriers are packed structs
package image_accel_pkg;

   // ==========================================================
   // register access port
   typedef struct packed {
      logic        valid;
      logic        write;
      logic [7:0]  addr;
      logic [31:0] wdata;
   } bus_req_t;

   typedef struct packed {
      logic        ack;
      logic        err;
      logic [31:0] rdata;
   } bus_rsp_t;

   // ==========================================================
   // control fields seen by the datapath
   typedef struct packed {
      logic       bottom_dummy_line_add;
      logic       auto_hot_point;
      logic       dma_burst_select;
      logic       dma_allow;
      logic       top_dummy_line_add;
      logic       pixel_format_select;
      logic       edge_dummy_column_add;
      logic       period_correction;
      logic [7:0] src_one_addr_high;
   } ctrl_t;

   // ==========================================================
   // module states
   typedef struct packed {
      logic flag;
   } flag_state_t;

   typedef struct packed {
      bus_rsp_t           rsp;
      logic               proc_error_irq_enable;
      logic               line_done_irq_enable;
      ctrl_t              ctrl;
      logic [13:0][31:0]  words;
      logic               irq;
   } regs_state_t;

endpackage

// >>> flag_cell.sv
// Purpose : sticky pending flag, set by hardware, cleared by software
// Assumes : set and clear come from logic on the same clock
// Notes   : a set in the clearing cycle wins
`timescale 1ns/1ps
`default_nettype none

module flag_cell (
   // clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic ce,
   // event and clear
   input  wire logic set_evt,
   input  wire logic clr,
   // flag
   output var  logic flag_q
);
   import image_accel_pkg::*;

   flag_state_t s_q;
   flag_state_t s_d;

   // ==========================================================
   // next state
   always_comb begin
      s_d = s_q;
      if (set_evt) begin
         // never lose an event that lands on a clear
         s_d.flag = 1'b1;
      end else if (clr) begin
         s_d.flag = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '0;
      end else if (ce) begin
         s_q <= s_d;
      end
   end

   assign flag_q = s_q.flag;

   // ==========================================================
   // checks
   property p_set_wins;
      @(posedge clk) disable iff (!rst_n)
      (ce && set_evt) |=> flag_q;
   endproperty
   a_set_wins: assert property (p_set_wins)
      else $error("event lost against a clear");

   property p_hold_frozen;
      @(posedge clk) disable iff (!rst_n)
      !ce |=> $stable(flag_q);
   endproperty
   a_hold_frozen: assert property (p_hold_frozen)
      else $error("flag moved while clock enable low");

endmodule // flag_cell

`default_nettype wire

// >>> cpu_bus_model.sv
// Purpose : processor side of the register port, one word per access
// Assumes : answer comes exactly one cycle after the taking edge
// Notes   : valid is held for the taking edge only, so no double take
`timescale 1ns/1ps
`default_nettype none

module cpu_bus_model (
   // clock
   input  wire logic                      clk,
   // register access
   output var  image_accel_pkg::bus_req_t bus_req,
   input  wire image_accel_pkg::bus_rsp_t bus_rsp
);
   import image_accel_pkg::*;

   // ==========================================================
   // bus cycle
   initial bus_req = '0;

   task automatic access(input  logic        w,
                         input  logic [7:0]  a,
                         input  logic [31:0] d,
                         output logic [31:0] q,
                         output logic        e,
                         output logic        ok);
      @(posedge clk);
      bus_req <= '{valid: 1'b1, write: w, addr: a, wdata: d};
      @(posedge clk);
      // released qualifiers show the inverse, never a stale copy
      bus_req <= '{valid: 1'b0, write: ~w, addr: ~a, wdata: ~d};
      @(posedge clk);
      ok = (bus_rsp.ack === 1'b1);
      e  = bus_rsp.err;
      q  = bus_rsp.rdata;
   endtask
endmodule // cpu_bus_model

`default_nettype wire

// >>> image_accel_ctrl_regs_tb.sv
// Purpose : self-checking bench of the accelerator register bank
// Assumes : cpu_bus_model drives the register port
// Notes   : a behavioural model predicts every read and output
`timescale 1ns/1ps
`default_nettype none

module image_accel_ctrl_regs_tb;
   import image_accel_pkg::*;

   // ==========================================================
   // signals and model state
   logic              clk = 1'b0;
   logic              resetn;
   logic              ce;
   logic              err_event;
   logic              line_done_event;
   logic              image_done;
   bus_req_t          bus_req;
   bus_rsp_t          bus_rsp;
   ctrl_t             ctrl;
   logic [13:0][31:0] cfg_words;
   logic              irq;
   int                fails = 0;
   int                tests_run = 0;
   int                cyc = 0;
   logic [31:0]       seed;
   logic [31:0]       mc_m;
   logic [31:0]       words_m [0:15];
   logic              ef_m;
   logic              lf_m;
   logic [7:0]        bad [4] = '{8'h3c, 8'h40, 8'h06, 8'hfc};

   always #4 clk = ~clk;

   image_accel_ctrl_regs dut (
      .clk             (clk),
      .resetn          (resetn),
      .ce              (ce),
      .bus_req         (bus_req),
      .bus_rsp         (bus_rsp),
      .err_event       (err_event),
      .line_done_event (line_done_event),
      .image_done      (image_done),
      .ctrl            (ctrl),
      .cfg_words       (cfg_words),
      .irq             (irq)
   );

   cpu_bus_model cpu (
      .clk     (clk),
      .bus_req (bus_req),
      .bus_rsp (bus_rsp)
   );

   // ==========================================================
   // helpers
   task automatic close_out;
      if (fails == 0 && tests_run > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                      input string msg);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("Error %0t: %s got %h exp %h", $time, msg, got, exp);
      end
   endtask

   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], 1'b0} ^ (x[31] ? 32'h0020_0003 : 32'h0);
   endfunction

   // software never writes unused bits and keeps the format at 1
   function automatic logic [31:0] legal(input logic [31:0] d);
      return (d & 32'h0033_ffff) | 32'h0000_0400;
   endfunction

   function automatic logic mapped(input logic [7:0] a);
      return a <= 8'h38 && a[1:0] == 2'b00;
   endfunction

   function automatic logic [31:0] model_rd(input logic [7:0] a);
      if (!mapped(a))
         return 32'h0;
      if (a == 8'h00)
         return mc_m | {10'h0, ef_m, lf_m, 20'h0};
      return words_m[a[5:2]];
   endfunction

   task automatic xfer(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
      logic [31:0] r;
      logic [31:0] exp;
      logic        er;
      logic        k;
      exp = model_rd(a);
      cpu.access(w, a, d, r, er, k);
      chk({31'h0, k}, 32'h1, "no ack");
      chk({31'h0, er}, {31'h0, !mapped(a)}, "err flag");
      if (!w)
         chk(r, exp, "read data");
      else if (a == 8'h00) begin
         ef_m = ef_m & d[21];
         lf_m = lf_m & d[20];
         mc_m = d & 32'h0003_ffff;
      end else if (mapped(a))
         words_m[a[5:2]] = d;
   endtask

   task automatic pulse(input int k);
      @(posedge clk);
      err_event       <= (k == 0);
      line_done_event <= (k == 1);
      image_done      <= (k == 2);
      @(posedge clk);
      err_event       <= 1'b0;
      line_done_event <= 1'b0;
      image_done      <= 1'b0;
      if (k == 0) ef_m = 1'b1;
      if (k == 1) lf_m = 1'b1;
      if (k == 2) mc_m[12] = 1'b0;
   endtask

   task automatic check_all;
      logic ie;
      repeat (2) @(posedge clk);
      #1;
      ie = (ef_m & mc_m[17]) | (lf_m & mc_m[16]);
      chk({16'h0, ctrl}, {16'h0, mc_m[15:0]}, "ctrl");
      chk({31'h0, irq}, {31'h0, ie}, "irq");
      for (int i = 0; i < 14; i++)
         chk(cfg_words[i], words_m[i + 1], "cfg word");
   endtask

   // ==========================================================
   // timeout
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         fails++;
         close_out;
      end
   end

   // ==========================================================
   // main sequence
   initial begin
      resetn = 1'b0;
      ce = 1'b1;
      err_event = 1'b0;
      line_done_event = 1'b0;
      image_done = 1'b0;
      seed = 32'h7e7a;
      mc_m = 32'h0000_0100;
      ef_m = 1'b0;
      lf_m = 1'b0;
      foreach (words_m[i])
         words_m[i] = 32'h0;
      repeat (6) @(posedge clk);
      resetn <= 1'b1;
      repeat (3) @(posedge clk);
      check_all;
      xfer(1'b0, 8'h00, 32'h0);
      for (int i = 1; i < 15; i++) begin
         seed = lfsr(seed);
         xfer(1'b1, 8'(i * 4), seed);
      end
      for (int i = 0; i < 15; i++)
         xfer(1'b0, 8'(i * 4), 32'h0);
      foreach (bad[i]) begin
         seed = lfsr(seed);
         xfer(1'b1, bad[i], seed);
         xfer(1'b0, bad[i], 32'h0);
      end
      for (int i = 0; i < 8; i++) begin
         seed = lfsr(seed);
         xfer(1'b1, 8'h00, legal(seed));
         xfer(1'b0, 8'h00, 32'h0);
         check_all;
      end
      // each flag with its enable off and on: pend, keep, clear
      for (int k = 0; k < 2; k++) begin
         for (int en = 0; en < 2; en++) begin
            seed = en ? (k ? 32'h0001_0000 : 32'h0002_0000) : 32'h0;
            xfer(1'b1, 8'h00, legal(seed));
            repeat (3) pulse(k);
            check_all;
            xfer(1'b0, 8'h00, 32'h0);
            xfer(1'b1, 8'h00, legal(seed | 32'h0030_0000));
            xfer(1'b0, 8'h00, 32'h0);
            check_all;
            xfer(1'b1, 8'h00, legal(seed));
            xfer(1'b0, 8'h00, 32'h0);
            check_all;
         end
      end
      xfer(1'b1, 8'h00, legal(32'h0000_3000));
      check_all;
      pulse(2);
      check_all;
      xfer(1'b0, 8'h00, 32'h0);
      // clock enable low: an event on that edge must leave no trace
      @(posedge clk);
      ce              <= 1'b0;
      line_done_event <= 1'b1;
      @(posedge clk);
      ce              <= 1'b1;
      line_done_event <= 1'b0;
      check_all;
      xfer(1'b0, 8'h00, 32'h0);
      close_out;
   end
endmodule // image_accel_ctrl_regs_tb

`default_nettype wire
